// >>> dcif_cfg.svh
// Constants for the DAC serial target and general pin block.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef DCIF_CFG_SVH
`define DCIF_CFG_SVH

`define DCIF_ADDR_HI       4'h9
`define DCIF_BCAST_ADDR    7'h47
`define DCIF_STRAP_GND     3'h0
`define DCIF_STRAP_VDD     3'h1
`define DCIF_STRAP_SDA     3'h2
`define DCIF_STRAP_SCL     3'h3
`define DCIF_BITS_PER_BYTE 4'h8
`define DCIF_BOOT_CYCLES   3'h4

`define DCIF_GPI_FAULT     4'h2
`define DCIF_GPI_IPDN      4'h3
`define DCIF_GPI_VPDN      4'h4
`define DCIF_GPI_PROTECT   4'h5
`define DCIF_GPI_CLEAR     4'h7
`define DCIF_GPI_LOAD      4'h8
`define DCIF_GPI_RESET     4'hb
`define DCIF_GPI_NVMPROG   4'hc
`define DCIF_GPI_WRLOCK    4'hd

`define DCIF_GPO_NVMBUSY   4'h1
`define DCIF_GPO_BUSY0     4'h4
`define DCIF_GPO_BUSY3     4'h7
`define DCIF_GPO_WIN0      4'h8
`define DCIF_GPO_WIN3      4'hb

`endif

// >>> dcif_pkg.sv
// Types shared by the DAC serial target and general pin block.
// Assumes nothing of its surroundings.
package dcif_pkg;

  typedef enum logic [2:0] {
    DCIF_IDLE,
    DCIF_ADDR,
    DCIF_ADDR_ACK,
    DCIF_RX,
    DCIF_RX_ACK,
    DCIF_TX,
    DCIF_TX_ACK
  } dcif_state_e;

endpackage

// >>> dcif_sync.sv
// Three-stage input synchroniser with agreement filter.
// Assumes asynchronous inputs and one system clock.
`timescale 1ns/1ps
module dcif_sync #(
  parameter int             W    = 1,
  parameter logic [W-1:0]   INIT = '1
) (
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] ff1;
  logic [W-1:0] ff2;
  logic [W-1:0] ff3;
  logic [W-1:0] next_dout;

  // A bit changes only once the second and third stages agree.
  always_comb begin
    for (int i = 0; i < W; i++) begin
      next_dout[i] = (ff2[i] == ff3[i]) ? ff3[i] : dout[i];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ff1  <= INIT;
      ff2  <= INIT;
      ff3  <= INIT;
      dout <= INIT;
    end else begin
      ff1  <= din;
      ff2  <= ff1;
      ff3  <= ff2;
      dout <= next_dout;
    end
  end

endmodule

// >>> dcif_strap.sv
// Address strap detector: tells which of four nets the strap is tied to.
// Assumes strap, clock and data lines come through matching synchronisers.
`timescale 1ns/1ps
`include "dcif_cfg.svh"
module dcif_strap (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       clear,
  input  wire logic       track,
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic       strap,
  output logic      [2:0] strap_addr
);

  logic diff_scl;
  logic diff_sda;
  logic next_diff_scl;
  logic next_diff_sda;

  // The strap is watched across the whole first byte of the frame.
  always_comb begin
    next_diff_scl = diff_scl;
    next_diff_sda = diff_sda;
    if (clear) begin
      next_diff_scl = 1'b0;
      next_diff_sda = 1'b0;
    end else if (track) begin
      next_diff_scl = diff_scl | (strap != scl);
      next_diff_sda = diff_sda | (strap != sda);
    end
    if (!diff_scl) begin
      strap_addr = `DCIF_STRAP_SCL;
    end else if (!diff_sda) begin
      strap_addr = `DCIF_STRAP_SDA;
    end else if (strap) begin
      strap_addr = `DCIF_STRAP_VDD;
    end else begin
      strap_addr = `DCIF_STRAP_GND;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      diff_scl <= 1'b0;
      diff_sda <= 1'b0;
    end else begin
      diff_scl <= next_diff_scl;
      diff_sda <= next_diff_sda;
    end
  end

endmodule

// >>> dcif_top.sv
// Serial target address decode and readback, plus the multifunction general pin.
// Assumes open-drain pins resolved outside and a register map served on the user ports.
`timescale 1ns/1ps
`include "dcif_cfg.svh"
module dcif_top
  import dcif_pkg::*;
#(
  parameter int NCH = 4
) (
  input  wire logic           sys_clk,
  input  wire logic           rst_n,
  input  wire logic           scl_in,
  input  wire logic           sda_in,
  output logic                sda_out,
  output logic                sda_oe_n,
  input  wire logic           addr_strap_pin,
  output logic                wr_strobe,
  output logic                wr_broadcast,
  output logic      [7:0]     wr_cmd,
  output logic      [15:0]    wr_data,
  output logic      [7:0]     rd_cmd,
  input  wire logic [15:0]    rd_data,
  input  wire logic           gp_in,
  output logic                gp_out,
  output logic                gp_oe_n,
  input  wire logic           pin_input_enable,
  input  wire logic           pin_output_enable,
  input  wire logic [3:0]     pin_input_function,
  input  wire logic [3:0]     pin_output_function,
  input  wire logic [NCH-1:0] pin_channel_select,
  input  wire logic [NCH-1:0] sync_config,
  input  wire logic           reset_config_stored,
  input  wire logic           sw_fault_snapshot,
  input  wire logic           sw_protect,
  input  wire logic           sw_clear_action,
  input  wire logic [NCH-1:0] sw_load_output_trigger,
  input  wire logic           memory_write_busy,
  input  wire logic [NCH-1:0] channel_busy,
  input  wire logic [NCH-1:0] window_compare_result,
  output logic                fault_snapshot,
  output logic                protect_action,
  output logic                clear_action,
  output logic      [NCH-1:0] load_output_trigger,
  output logic      [NCH-1:0] current_powerdown,
  output logic      [NCH-1:0] voltage_powerdown,
  output logic                pin_device_reset,
  output logic                nvm_prog_allow,
  output logic                reg_write_block
);

  logic [3:0] sync_q;
  logic       scl;
  logic       sda;
  logic       strap;
  logic       gp;
  logic       scl_d;
  logic       sda_d;
  logic [2:0] strap_addr;

  dcif_sync #(.W(4), .INIT(4'hf)) u_sync (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .din     ({scl_in, sda_in, addr_strap_pin, gp_in}),
    .dout    (sync_q)
  );

  assign {scl, sda, strap, gp} = sync_q;

  wire scl_rise = scl & ~scl_d;
  wire scl_fall = ~scl & scl_d;
  wire start_c  = scl & scl_d & sda_d & ~sda;
  wire stop_c   = scl & scl_d & ~sda_d & sda;

  dcif_state_e state;
  dcif_state_e next_state;
  logic [3:0]  bitcnt;
  logic [3:0]  next_bitcnt;
  logic [7:0]  shreg;
  logic [7:0]  next_shreg;
  logic [1:0]  byte_idx;
  logic [1:0]  next_byte_idx;
  logic        bcast;
  logic        next_bcast;
  logic        tx_low;
  logic        next_tx_low;
  logic [7:0]  tx_lsb;
  logic [7:0]  next_tx_lsb;
  logic [7:0]  last_wr;
  logic [7:0]  next_last_wr;
  logic [7:0]  next_rd_cmd;
  logic        next_sda_oe_n;
  logic        next_wr_strobe;
  logic        next_wr_broadcast;
  logic [7:0]  next_wr_cmd;
  logic [15:0] next_wr_data;

  dcif_strap u_strap (
    .sys_clk    (sys_clk),
    .rst_n      (rst_n),
    .clear      (start_c),
    .track      (state == DCIF_ADDR),
    .scl        (scl),
    .sda        (sda),
    .strap      (strap),
    .strap_addr (strap_addr)
  );

  // Serial target state machine.
  always_comb begin
    next_state        = state;
    next_bitcnt       = bitcnt;
    next_shreg        = shreg;
    next_byte_idx     = byte_idx;
    next_bcast        = bcast;
    next_tx_low       = tx_low;
    next_tx_lsb       = tx_lsb;
    next_last_wr      = last_wr;
    next_rd_cmd       = rd_cmd;
    next_sda_oe_n     = sda_oe_n;
    next_wr_strobe    = 1'b0;
    next_wr_broadcast = wr_broadcast;
    next_wr_cmd       = wr_cmd;
    next_wr_data      = wr_data;
    if (stop_c) begin
      next_state    = DCIF_IDLE;
      next_sda_oe_n = 1'b1;
    end else if (start_c) begin
      if (state == DCIF_IDLE) begin
        next_rd_cmd = last_wr;
      end
      next_state    = DCIF_ADDR;
      next_bitcnt   = 4'h0;
      next_sda_oe_n = 1'b1;
    end else if (scl_rise) begin
      case (state)
        DCIF_ADDR, DCIF_RX: begin
          next_shreg  = {shreg[6:0], sda};
          next_bitcnt = bitcnt + 4'h1;
        end
        DCIF_TX_ACK: begin
          if (sda) begin
            next_state = DCIF_IDLE;
          end
        end
        default: begin
        end
      endcase
    end else if (scl_fall) begin
      case (state)
        DCIF_ADDR: begin
          if (bitcnt == `DCIF_BITS_PER_BYTE) begin
            next_bcast = 1'b0;
            if (shreg[7:1] == {`DCIF_ADDR_HI, strap_addr}) begin
              next_state    = DCIF_ADDR_ACK;
              next_sda_oe_n = 1'b0;
            end else if (shreg[7:1] == `DCIF_BCAST_ADDR && !shreg[0]) begin
              next_bcast    = 1'b1;
              next_state    = DCIF_ADDR_ACK;
              next_sda_oe_n = 1'b0;
            end else begin
              next_state = DCIF_IDLE;
            end
          end
        end
        DCIF_ADDR_ACK: begin
          next_bitcnt   = 4'h0;
          next_byte_idx = 2'h0;
          if (shreg[0]) begin
            next_state    = DCIF_TX;
            next_tx_lsb   = rd_data[7:0];
            next_shreg    = {rd_data[14:8], 1'b0};
            next_sda_oe_n = rd_data[15];
            next_bitcnt   = 4'h1;
            next_tx_low   = 1'b0;
          end else begin
            next_state    = DCIF_RX;
            next_sda_oe_n = 1'b1;
          end
        end
        DCIF_RX: begin
          if (bitcnt == `DCIF_BITS_PER_BYTE) begin
            next_state    = DCIF_RX_ACK;
            next_sda_oe_n = 1'b0;
            case (byte_idx)
              2'h0: begin
                next_wr_cmd = shreg;
                next_rd_cmd = shreg;
              end
              2'h1: begin
                next_wr_data[15:8] = shreg;
              end
              default: begin
                next_wr_data[7:0] = shreg;
                next_wr_strobe    = 1'b1;
                next_wr_broadcast = bcast;
                next_last_wr      = wr_cmd;
                next_rd_cmd       = wr_cmd;
              end
            endcase
            next_byte_idx = (byte_idx == 2'h2) ? 2'h0 : byte_idx + 2'h1;
          end
        end
        DCIF_RX_ACK: begin
          next_state    = DCIF_RX;
          next_bitcnt   = 4'h0;
          next_sda_oe_n = 1'b1;
        end
        DCIF_TX: begin
          if (bitcnt == `DCIF_BITS_PER_BYTE) begin
            next_state    = DCIF_TX_ACK;
            next_sda_oe_n = 1'b1;
          end else begin
            next_sda_oe_n = shreg[7];
            next_shreg    = {shreg[6:0], 1'b0};
            next_bitcnt   = bitcnt + 4'h1;
          end
        end
        DCIF_TX_ACK: begin
          if (tx_low) begin
            next_state = DCIF_IDLE;
          end else begin
            next_state    = DCIF_TX;
            next_tx_low   = 1'b1;
            next_sda_oe_n = tx_lsb[7];
            next_shreg    = {tx_lsb[6:0], 1'b0};
            next_bitcnt   = 4'h1;
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      scl_d        <= 1'b1;
      sda_d        <= 1'b1;
      state        <= DCIF_IDLE;
      bitcnt       <= 4'h0;
      shreg        <= 8'h00;
      byte_idx     <= 2'h0;
      bcast        <= 1'b0;
      tx_low       <= 1'b0;
      tx_lsb       <= 8'h00;
      last_wr      <= 8'h00;
      rd_cmd       <= 8'h00;
      sda_oe_n     <= 1'b1;
      sda_out      <= 1'b0;
      wr_strobe    <= 1'b0;
      wr_broadcast <= 1'b0;
      wr_cmd       <= 8'h00;
      wr_data      <= 16'h0000;
    end else begin
      scl_d        <= scl;
      sda_d        <= sda;
      state        <= next_state;
      bitcnt       <= next_bitcnt;
      shreg        <= next_shreg;
      byte_idx     <= next_byte_idx;
      bcast        <= next_bcast;
      tx_low       <= next_tx_low;
      tx_lsb       <= next_tx_lsb;
      last_wr      <= next_last_wr;
      rd_cmd       <= next_rd_cmd;
      sda_oe_n     <= next_sda_oe_n;
      sda_out      <= 1'b0;
      wr_strobe    <= next_wr_strobe;
      wr_broadcast <= next_wr_broadcast;
      wr_cmd       <= next_wr_cmd;
      wr_data      <= next_wr_data;
    end
  end

  // General pin logic.
  logic           gp_d;
  logic [2:0]     boot_cnt;
  logic [2:0]     next_boot_cnt;
  logic           next_fault;
  logic           next_protect;
  logic           next_clear;
  logic [NCH-1:0] next_load;
  logic [NCH-1:0] next_ipdn;
  logic [NCH-1:0] next_vpdn;
  logic           next_reset;
  logic           next_nvm_allow;
  logic           next_wr_block;
  logic           next_gp_out;
  logic           next_gp_oe_n;
  logic           in_on;
  logic           fall;
  logic [3:0]     ofn;

  always_comb begin
    in_on         = pin_input_enable;
    next_boot_cnt = (boot_cnt == `DCIF_BOOT_CYCLES) ? boot_cnt : boot_cnt + 3'h1;
    // The first settled level counts as a falling edge when low.
    fall = (boot_cnt == `DCIF_BOOT_CYCLES - 3'h1) ? ~gp : (gp_d & ~gp);
    if (boot_cnt < `DCIF_BOOT_CYCLES - 3'h1) begin
      fall = 1'b0;
    end
    // A mapped function masks its software trigger.
    next_fault   = (in_on && pin_input_function == `DCIF_GPI_FAULT) ? fall : sw_fault_snapshot;
    next_protect = (in_on && pin_input_function == `DCIF_GPI_PROTECT) ? fall : sw_protect;
    next_clear   = (in_on && pin_input_function == `DCIF_GPI_CLEAR) ? fall : sw_clear_action;
    next_load    = sw_load_output_trigger;
    if (in_on && pin_input_function == `DCIF_GPI_LOAD) begin
      next_load = fall ? (pin_channel_select & sync_config) : '0;
    end
    next_ipdn = '0;
    next_vpdn = '0;
    if (in_on && pin_input_function == `DCIF_GPI_IPDN) begin
      next_ipdn = gp ? '0 : pin_channel_select;
    end
    if (in_on && pin_input_function == `DCIF_GPI_VPDN) begin
      next_vpdn = gp ? '0 : pin_channel_select;
    end
    next_reset     = in_on && pin_input_function == `DCIF_GPI_RESET && reset_config_stored && !gp;
    next_nvm_allow = !(in_on && pin_input_function == `DCIF_GPI_NVMPROG && gp);
    next_wr_block  = in_on && pin_input_function == `DCIF_GPI_WRLOCK && gp;
    ofn            = pin_output_function;
    next_gp_out    = 1'b0;
    next_gp_oe_n   = 1'b1;
    if (pin_output_enable && !in_on) begin
      if (ofn == `DCIF_GPO_NVMBUSY) begin
        next_gp_out  = memory_write_busy;
        next_gp_oe_n = 1'b0;
      end else if (ofn >= `DCIF_GPO_BUSY0 && ofn <= `DCIF_GPO_BUSY3) begin
        next_gp_out  = channel_busy[ofn[1:0]];
        next_gp_oe_n = 1'b0;
      end else if (ofn >= `DCIF_GPO_WIN0 && ofn <= `DCIF_GPO_WIN3) begin
        next_gp_out  = window_compare_result[ofn[1:0]];
        next_gp_oe_n = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      gp_d                <= 1'b1;
      boot_cnt            <= 3'h0;
      fault_snapshot      <= 1'b0;
      protect_action      <= 1'b0;
      clear_action        <= 1'b0;
      load_output_trigger <= '0;
      current_powerdown   <= '0;
      voltage_powerdown   <= '0;
      pin_device_reset    <= 1'b0;
      nvm_prog_allow      <= 1'b1;
      reg_write_block     <= 1'b0;
      gp_out              <= 1'b0;
      gp_oe_n             <= 1'b1;
    end else begin
      gp_d                <= gp;
      boot_cnt            <= next_boot_cnt;
      fault_snapshot      <= next_fault;
      protect_action      <= next_protect;
      clear_action        <= next_clear;
      load_output_trigger <= next_load;
      current_powerdown   <= next_ipdn;
      voltage_powerdown   <= next_vpdn;
      pin_device_reset    <= next_reset;
      nvm_prog_allow      <= next_nvm_allow;
      reg_write_block     <= next_wr_block;
      gp_out              <= next_gp_out;
      gp_oe_n             <= next_gp_oe_n;
    end
  end

endmodule

// >>> dcif_bus_host.sv
// Bus controller model: drives the bus clock and a pulled-up data wire.
// Assumes the bench calls its tasks and feeds back the device data drive.
`timescale 1ns/1ps
module dcif_bus_host (
  input  wire logic sys_clk,
  input  wire logic sda_out,
  input  wire logic sda_oe_n,
  output logic      scl,
  output logic      sda
);
  logic drv = 1'b1;
  initial scl = 1'b1;
  // A released wire is pulled high.
  assign sda = drv & (sda_oe_n | sda_out);
  task automatic half();
    repeat (20) @(posedge sys_clk);
    #1;
  endtask
  task automatic start();
    drv = 1'b1;
    half();
    scl = 1'b1;
    half();
    drv = 1'b0;
    half();
    scl = 1'b0;
    half();
  endtask
  task automatic stop();
    drv = 1'b0;
    half();
    scl = 1'b1;
    half();
    drv = 1'b1;
    half();
  endtask
  // Data changes only in the middle of the low phase.
  task automatic xbit(input logic b, output logic r);
    drv = b;
    half();
    scl = 1'b1;
    half();
    r = sda;
    scl = 1'b0;
    half();
  endtask
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) xbit(b[i], r);
    xbit(1'b1, r);
    ack = !r;
  endtask
  task automatic rbyte(output logic [7:0] b, input logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) xbit(1'b1, b[i]);
    xbit(!ack, r);
  endtask
endmodule

// >>> dcif_top_assertions.sv
// Checker for the serial target and general pin block.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
module dcif_top_checker #(
  parameter int NCH = 4
) (
  input wire logic           sys_clk,
  input wire logic           rst_n,
  input wire logic           scl_in,
  input wire logic           sda_oe_n,
  input wire logic           gp_in,
  input wire logic           gp_out,
  input wire logic           gp_oe_n,
  input wire logic           wr_strobe,
  input wire logic           wr_broadcast,
  input wire logic           pin_input_enable,
  input wire logic           pin_output_enable,
  input wire logic [3:0]     pin_input_function,
  input wire logic [3:0]     pin_output_function,
  input wire logic [NCH-1:0] pin_channel_select,
  input wire logic           sw_protect,
  input wire logic           sw_clear_action,
  input wire logic           memory_write_busy,
  input wire logic [NCH-1:0] channel_busy,
  input wire logic [NCH-1:0] window_compare_result,
  input wire logic           protect_action,
  input wire logic           clear_action,
  input wire logic [NCH-1:0] current_powerdown,
  input wire logic [NCH-1:0] voltage_powerdown,
  input wire logic           nvm_prog_allow,
  input wire logic           reg_write_block
);
  logic ipin, drv, exp_gp;
  always_comb begin
    ipin = pin_input_enable;
    drv = pin_output_enable && !ipin && (pin_output_function == 4'h1 || pin_output_function inside {[4'h4:4'hb]});
    exp_gp = pin_output_function == 4'h1 ? memory_write_busy : pin_output_function[3] ?
      window_compare_result[pin_output_function[1:0]] : channel_busy[pin_output_function[1:0]];
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  property p_sw_pass;
    sw_clear_action && !(ipin && pin_input_function == 4'h7) |=> clear_action;
  endproperty
  a_sw_pass: assert property (p_sw_pass) else $error("software clear not passed");
  property p_protect_src;
    protect_action && !(ipin && pin_input_function == 4'h5) |-> $past(sw_protect);
  endproperty
  a_protect_src: assert property (p_protect_src) else $error("protect without cause");
  property p_ipdn;
    (ipin && pin_input_function == 4'h3 && $stable(gp_in) && $stable(pin_channel_select))[*8]
      |-> current_powerdown == (gp_in ? '0 : pin_channel_select);
  endproperty
  a_ipdn: assert property (p_ipdn) else $error("current powerdown wrong");
  property p_vpdn;
    (ipin && pin_input_function == 4'h4 && $stable(gp_in) && $stable(pin_channel_select))[*8]
      |-> voltage_powerdown == (gp_in ? '0 : pin_channel_select);
  endproperty
  a_vpdn: assert property (p_vpdn) else $error("voltage powerdown wrong");
  property p_nvm;
    (ipin && pin_input_function == 4'hc && $stable(gp_in))[*8] |-> nvm_prog_allow == !gp_in;
  endproperty
  a_nvm: assert property (p_nvm) else $error("programming gate wrong");
  property p_wrlock;
    (ipin && pin_input_function == 4'hd && $stable(gp_in))[*8] |-> reg_write_block == gp_in;
  endproperty
  a_wrlock: assert property (p_wrlock) else $error("write lock wrong");
  property p_gp_drive;
    (drv && $stable({pin_output_function, memory_write_busy, channel_busy, window_compare_result}))[*3]
      |-> !gp_oe_n && gp_out == exp_gp;
  endproperty
  a_gp_drive: assert property (p_gp_drive) else $error("pin status output wrong");
  property p_gp_quiet;
    (!drv)[*3] |-> gp_oe_n;
  endproperty
  a_gp_quiet: assert property (p_gp_quiet) else $error("pin driven without function");
  property p_ack_low;
    $fell(sda_oe_n) |-> !scl_in;
  endproperty
  a_ack_low: assert property (p_ack_low) else $error("data driven with clock high");
  c_clear: cover property (clear_action);
  c_bcast: cover property (wr_strobe && wr_broadcast);
  c_drive: cover property (!gp_oe_n);
endmodule
bind dcif_top dcif_top_checker #(.NCH(NCH)) chk_i (.sys_clk, .rst_n, .scl_in, .sda_oe_n, .gp_in, .gp_out,
  .gp_oe_n, .wr_strobe, .wr_broadcast, .pin_input_enable, .pin_output_enable, .pin_input_function,
  .pin_output_function, .pin_channel_select, .sw_protect, .sw_clear_action, .memory_write_busy, .channel_busy,
  .window_compare_result, .protect_action, .clear_action, .current_powerdown, .voltage_powerdown,
  .nvm_prog_allow, .reg_write_block);

// >>> dac_i2c_addr_and_gpio_triggers_bench.sv
// Self-checking bench: bus frames and general pin functions against a bench model.
// Assumes the host model and checker are compiled first.
`timescale 1ns/1ps
module dac_i2c_addr_and_gpio_triggers_bench;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        scl_in, sda_in, sda_out, sda_oe_n, gp_out, gp_oe_n, def, v;
  logic        wr_strobe, wr_broadcast, pin_device_reset, nvm_prog_allow, reg_write_block;
  logic        fault_snapshot, protect_action, clear_action;
  logic [7:0]  wr_cmd, rd_cmd;
  logic [15:0] wr_data;
  logic [3:0]  load_output_trigger, current_powerdown, voltage_powerdown;
  logic [1:0]  smode = 2'h0;
  logic        gp_lvl = 1'b1, pin_input_enable = 1'b0, pin_output_enable = 1'b0, reset_config_stored = 1'b0;
  logic [3:0]  pin_input_function = 4'h0, pin_output_function = 4'h0, pin_channel_select = 4'h0;
  logic [3:0]  sync_config = 4'h0, sw_load_output_trigger = 4'h0, channel_busy = 4'h0;
  logic [3:0]  window_compare_result = 4'h0;
  logic        sw_fault_snapshot = 1'b0, sw_protect = 1'b0, sw_clear_action = 1'b0, memory_write_busy = 1'b0;
  logic [31:0] seed = 32'ha;
  logic [7:0]  last_cmd = 8'h0;
  logic [24:0] wr_seen;
  logic [3:0]  ld_seen;
  logic [3:0]  ecode [5] = '{4'h2, 4'h5, 4'h7, 4'h6, 4'he};
  logic [1:0]  gexp [4] = '{2'h2, 2'h0, 2'h2, 2'h3};
  int          n_fail, num_checks, n_wr, n_fs, n_pa, n_ca;
  wire         addr_strap_pin = smode == 2'h0 ? 1'b0 : smode == 2'h1 ? 1'b1 : smode == 2'h2 ? sda_in : scl_in;
  wire         gp_in = gp_oe_n ? gp_lvl : gp_out;
  wire  [15:0] rd_data = {rd_cmd, ~rd_cmd};
  always #5 sys_clk = ~sys_clk;
  dcif_bus_host host (.sys_clk, .sda_out, .sda_oe_n, .scl(scl_in), .sda(sda_in));
  dcif_top #(.NCH(4)) dut (.sys_clk, .rst_n, .scl_in, .sda_in, .sda_out, .sda_oe_n, .addr_strap_pin,
    .wr_strobe, .wr_broadcast, .wr_cmd, .wr_data, .rd_cmd, .rd_data, .gp_in, .gp_out, .gp_oe_n,
    .pin_input_enable, .pin_output_enable, .pin_input_function, .pin_output_function, .pin_channel_select,
    .sync_config, .reset_config_stored, .sw_fault_snapshot, .sw_protect, .sw_clear_action,
    .sw_load_output_trigger, .memory_write_busy, .channel_busy, .window_compare_result, .fault_snapshot,
    .protect_action, .clear_action, .load_output_trigger, .current_powerdown, .voltage_powerdown,
    .pin_device_reset, .nvm_prog_allow, .reg_write_block);
  always @(posedge sys_clk) begin
    if (wr_strobe === 1'b1) begin
      n_wr++;
      wr_seen = {wr_broadcast, wr_cmd, wr_data};
    end
    if (fault_snapshot === 1'b1) n_fs++;
    if (protect_action === 1'b1) n_pa++;
    if (clear_action === 1'b1) n_ca++;
    ld_seen = ld_seen | load_output_trigger;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    if (n_fail == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic frame_w(input logic [6:0] a, input logic ak);
    logic        k;
    logic [7:0]  c;
    logic [15:0] d;
    int          n0;
    {c, d} = 24'(rnd());
    n0 = n_wr;
    host.start();
    host.wbyte({a, 1'b0}, k);
    chk(k, ak);
    if (k) begin
      host.wbyte(c, k);
      host.wbyte(d[15:8], k);
      host.wbyte(d[7:0], k);
      chk(k, 1'b1);
      last_cmd = c;
    end
    host.stop();
    cyc(10);
    chk(n_wr - n0, ak);
    if (ak) chk(wr_seen, {a == 7'h47, c, d});
  endtask
  task automatic frame_r(input logic [6:0] a, input logic wc, input logic ak);
    logic       k;
    logic [7:0] c, u, l;
    c = wc ? 8'(rnd()) : last_cmd;
    if (wc) begin
      host.start();
      host.wbyte({a, 1'b0}, k);
      host.wbyte(c, k);
    end
    host.start();
    host.wbyte({a, 1'b1}, k);
    chk(k, ak);
    if (k) begin
      host.rbyte(u, 1'b1);
      host.rbyte(l, 1'b0);
      chk({u, l}, {c, ~c});
    end
    host.stop();
  endtask
  task automatic pin_to(input logic lv);
    gp_lvl = lv;
    cyc(15);
  endtask
  initial begin
    cyc(4);
    rst_n = 1'b1;
    cyc(8);
    for (int s = 0; s < 4; s++) begin
      smode = 2'(s);
      frame_w({4'h9, 1'b0, smode}, 1'b1);
      frame_w({4'h9, 1'b1, smode}, 1'b0);
      frame_w({4'h1, 1'b0, smode}, 1'b0);
      frame_r({4'h9, 1'b0, smode}, 1'b1, 1'b1);
      frame_r({4'h9, 1'b0, smode}, 1'b0, 1'b1);
    end
    frame_w(7'h47, 1'b1);
    frame_r(7'h47, 1'b0, 1'b0);
    pin_input_enable = 1'b1;
    for (int i = 0; i < 5; i++) begin
      pin_input_function = ecode[i];
      cyc(10);
      {n_fs, n_pa, n_ca} = '0;
      pin_to(1'b0);
      pin_to(1'b1);
      {sw_fault_snapshot, sw_protect, sw_clear_action} = 3'h7;
      cyc(1);
      {sw_fault_snapshot, sw_protect, sw_clear_action} = 3'h0;
      cyc(6);
      chk({n_fs[3:0], n_pa[3:0], n_ca[3:0]}, 12'h111);
    end
    pin_input_function = 4'h8;
    {pin_channel_select, sync_config} = 8'(rnd());
    cyc(10);
    ld_seen = 4'h0;
    pin_to(1'b0);
    sw_load_output_trigger = 4'hf;
    cyc(1);
    sw_load_output_trigger = 4'h0;
    pin_to(1'b1);
    chk(ld_seen, pin_channel_select & sync_config);
    for (int i = 0; i < 2; i++) begin
      pin_input_function = 4'h3 + 4'(i);
      pin_channel_select = 4'(rnd());
      pin_to(1'b0);
      chk({current_powerdown, voltage_powerdown}, i ? {4'h0, pin_channel_select} : {pin_channel_select, 4'h0});
      pin_to(1'b1);
      chk({current_powerdown, voltage_powerdown}, 8'h0);
    end
    pin_input_function = 4'hb;
    for (int r = 0; r < 2; r++) begin
      reset_config_stored = r[0];
      pin_to(1'b0);
      chk(pin_device_reset, r[0]);
      pin_to(1'b1);
      chk(pin_device_reset, 1'b0);
    end
    for (int j = 0; j < 4; j++) begin
      pin_input_function = j < 2 ? 4'hc : 4'hd;
      pin_to(j[0]);
      chk({nvm_prog_allow, reg_write_block}, gexp[j]);
    end
    pin_output_enable = 1'b1;
    for (int f = 0; f < 17; f++) begin
      pin_output_function = f == 16 ? 4'h1 : 4'(f);
      pin_input_enable = f == 16;
      {memory_write_busy, channel_busy, window_compare_result} = 9'(rnd());
      cyc(6);
      def = f == 1 || (f >= 4 && f <= 11);
      v = f == 1 ? memory_write_busy : f < 8 ? channel_busy[f[1:0]] : window_compare_result[f[1:0]];
      chk(gp_oe_n, !def);
      if (def) chk(gp_out, v);
    end
    pin_output_enable = 1'b0;
    pin_input_function = 4'h7;
    gp_lvl = 1'b0;
    rst_n = 1'b0;
    cyc(4);
    n_ca = 0;
    rst_n = 1'b1;
    cyc(12);
    chk(n_ca, 1);
    final_report();
  end
  initial begin
    cyc(90000);
    n_fail++;
    final_report();
  end
endmodule
